// file: hdl/port_fc_pkg.sv
/*
 * Package for the port one flow-control register bank: register offset,
 * bit positions, reset values and the packed structs that carry requests,
 * straps and negotiation results.
 * Assumes a single 32-bit system register space addressed by byte offset.
 */
package port_fc_pkg;

    // Register space geometry.
    localparam int ADDR_W = 12;
    localparam int DATA_W = 32;
    localparam logic [ADDR_W-1:0] FC_REG_OFFSET = 12'h1A0;

    // Bit positions inside the flow-control register.
    localparam int BIT_BP_EN = 6;
    localparam int BIT_DUPLEX = 5;
    localparam int BIT_RX_ACTIVE = 4;
    localparam int BIT_TX_ACTIVE = 3;
    localparam int BIT_RX_EN = 2;
    localparam int BIT_TX_EN = 1;
    localparam int BIT_MAN_SEL = 0;
    localparam int RESV_LO = 7;

    // Reset values held until the straps are captured.
    localparam logic CTRL_RESET = 1'h0;
    localparam logic DUPLEX_RESET = 1'h0;
    localparam logic [DATA_W-1:0] READ_ZERO = 32'h0;

    // One register access from the system side.
    typedef struct packed {
        logic wr;
        logic rd;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
    } csr_req_s;

    // Strap values, either sampled at reset or rewritten by the loader.
    typedef struct packed {
        logic backpressure_default_strap;
        logic pause_enable_default_strap;
        logic manual_select_default_strap;
    } strap_s;

    // Port link state and auto-negotiation outcome.
    typedef struct packed {
        logic autoneg_enable;
        logic half_duplex;
        logic an_rx_pause;
        logic an_tx_pause;
    } link_s;

    // Effective flow-control settings driven to the port MAC.
    typedef struct packed {
        logic port1_backpressure_enable;
        logic port1_rx_pause_active;
        logic port1_tx_pause_active;
        logic port1_duplex_status;
    } fc_out_s;

endpackage : port_fc_pkg

// file: hdl/port_fc_select.sv
/*
 * Port one flow-control select register and its enable logic.
 * Assumes the register access, strap, loader and link inputs are synchronous
 * to CLK_I, and that a loader reload is a single-cycle pulse.
 */
`timescale 1ns/1ps
`default_nettype none

module port_fc_select
(
    // Clock and reset.
    input wire logic CLK_I,
    input wire logic RST_I,
    // Register access.
    input wire port_fc_pkg::csr_req_s CSR_REQ_I,
    output logic [port_fc_pkg::DATA_W-1:0] CSR_RDATA_O,
    output logic CSR_RVALID_O,
    // Straps and loader reload.
    input wire port_fc_pkg::strap_s STRAP_I,
    input wire logic STRAP_RELOAD_I,
    // Link state from the PHY.
    input wire port_fc_pkg::link_s LINK_I,
    // Effective settings to the port MAC.
    output port_fc_pkg::fc_out_s FC_O
);
    import port_fc_pkg::*;

    ////////////////////////////////////////////////////////////////////////////

    logic hit;
    logic bp_q, bp_d;
    logic rx_en_q, rx_en_d;
    logic tx_en_q, tx_en_d;
    logic msel_q, msel_d;
    logic loaded_q, loaded_d;
    logic dup_q, dup_d;
    logic crx_q, crx_d;
    logic ctx_q, ctx_d;
    logic use_manual;
    logic [DATA_W-1:0] rdata_q, rdata_d;
    logic rvalid_q, rvalid_d;

    // Address decode for the single register of this bank.
    assign hit = (CSR_REQ_I.addr == FC_REG_OFFSET);

    ////////////////////////////////////////////////////////////////////////////

    // Control bits: straps load first after reset and on every reload, which
    // wins over a software write landing in the same cycle.
    always_comb
    begin
        loaded_d = 1'h1;
        bp_d = bp_q;
        rx_en_d = rx_en_q;
        tx_en_d = tx_en_q;
        msel_d = msel_q;
        if (!loaded_q || STRAP_RELOAD_I)
        begin
            bp_d = STRAP_I.backpressure_default_strap;
            rx_en_d = STRAP_I.pause_enable_default_strap;
            tx_en_d = STRAP_I.pause_enable_default_strap;
            msel_d = STRAP_I.manual_select_default_strap;
        end
        else if (CSR_REQ_I.wr && hit)
        begin
            // Only the four writable bits are stored; nothing goes to the PHY.
            bp_d = CSR_REQ_I.wdata[BIT_BP_EN];
            rx_en_d = CSR_REQ_I.wdata[BIT_RX_EN];
            tx_en_d = CSR_REQ_I.wdata[BIT_TX_EN];
            msel_d = CSR_REQ_I.wdata[BIT_MAN_SEL];
        end
    end

    // Registers the control bits; the strap capture waits for reset release.
    always_ff @(posedge CLK_I or posedge RST_I)
    begin
        if (RST_I)
        begin
            loaded_q <= 1'h0;
            bp_q <= CTRL_RESET;
            rx_en_q <= CTRL_RESET;
            tx_en_q <= CTRL_RESET;
            msel_q <= CTRL_RESET;
        end
        else
        begin
            loaded_q <= loaded_d;
            bp_q <= bp_d;
            rx_en_q <= rx_en_d;
            tx_en_q <= tx_en_d;
            msel_q <= msel_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////

    // Source select: manual bits when forced or when negotiation is off.
    assign use_manual = msel_q || !LINK_I.autoneg_enable;

    // Effective status; pause only operates in full duplex, so half duplex
    // forces both pause directions off whichever source is selected.
    always_comb
    begin
        dup_d = LINK_I.half_duplex;
        crx_d = 1'h0;
        ctx_d = 1'h0;
        if (!LINK_I.half_duplex)
        begin
            if (use_manual)
            begin
                crx_d = rx_en_q;
                ctx_d = tx_en_q;
            end
            else
            begin
                crx_d = LINK_I.an_rx_pause;
                ctx_d = LINK_I.an_tx_pause;
            end
        end
    end

    // Registers the status; reset loads fixed values, and the captured straps reach it one cycle after capture.
    always_ff @(posedge CLK_I or posedge RST_I)
    begin
        if (RST_I)
        begin
            dup_q <= DUPLEX_RESET;
            crx_q <= CTRL_RESET;
            ctx_q <= CTRL_RESET;
        end
        else
        begin
            dup_q <= dup_d;
            crx_q <= crx_d;
            ctx_q <= ctx_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////

    // Read data: the register image on a hit, zero elsewhere, one cycle later.
    always_comb
    begin
        rvalid_d = CSR_REQ_I.rd;
        rdata_d = READ_ZERO;
        if (CSR_REQ_I.rd && hit)
        begin
            rdata_d[BIT_BP_EN] = bp_q;
            rdata_d[BIT_DUPLEX] = dup_q;
            rdata_d[BIT_RX_ACTIVE] = crx_q;
            rdata_d[BIT_TX_ACTIVE] = ctx_q;
            rdata_d[BIT_RX_EN] = rx_en_q;
            rdata_d[BIT_TX_EN] = tx_en_q;
            rdata_d[BIT_MAN_SEL] = msel_q;
        end
    end

    // Registers the read answer.
    always_ff @(posedge CLK_I or posedge RST_I)
    begin
        if (RST_I)
        begin
            rdata_q <= READ_ZERO;
            rvalid_q <= 1'h0;
        end
        else
        begin
            rdata_q <= rdata_d;
            rvalid_q <= rvalid_d;
        end
    end

    // Output drive.
    assign CSR_RDATA_O = rdata_q;
    assign CSR_RVALID_O = rvalid_q;
    assign FC_O.port1_backpressure_enable = bp_q;
    assign FC_O.port1_rx_pause_active = crx_q;
    assign FC_O.port1_tx_pause_active = ctx_q;
    assign FC_O.port1_duplex_status = dup_q;

    ////////////////////////////////////////////////////////////////////////////

    // Checks on the behaviour above.
    sequence s_sw_write;
        loaded_q && !STRAP_RELOAD_I && CSR_REQ_I.wr && hit;
    endsequence

    sequence s_strap_load;
        !loaded_q || STRAP_RELOAD_I;
    endsequence

    property p_bp_write;
        @(posedge CLK_I) disable iff (RST_I)
        s_sw_write |=> (bp_q == $past(CSR_REQ_I.wdata[BIT_BP_EN])) && (FC_O.port1_backpressure_enable == bp_q);
    endproperty
    a_bp_write: assert property (p_bp_write) else $error("backpressure bit did not take the write");

    property p_duplex;
        @(posedge CLK_I) disable iff (RST_I)
        1'h1 |=> dup_q == $past(LINK_I.half_duplex);
    endproperty
    a_duplex: assert property (p_duplex) else $error("duplex status does not follow the link");

    property p_auto_follow;
        @(posedge CLK_I) disable iff (RST_I)
        (!msel_q && LINK_I.autoneg_enable && !LINK_I.half_duplex)
        |=> (crx_q == $past(LINK_I.an_rx_pause)) && (ctx_q == $past(LINK_I.an_tx_pause));
    endproperty
    a_auto_follow: assert property (p_auto_follow) else $error("status does not follow negotiation");

    property p_an_off_manual;
        @(posedge CLK_I) disable iff (RST_I)
        (!LINK_I.autoneg_enable && !LINK_I.half_duplex)
        |=> (crx_q == $past(rx_en_q)) && (ctx_q == $past(tx_en_q));
    endproperty
    a_an_off_manual: assert property (p_an_off_manual) else $error("manual bits unused with negotiation off");

    property p_forced_manual;
        @(posedge CLK_I) disable iff (RST_I)
        (msel_q && !LINK_I.half_duplex) |=> (crx_q == $past(rx_en_q)) && (ctx_q == $past(tx_en_q));
    endproperty
    a_forced_manual: assert property (p_forced_manual) else $error("manual select not honoured");

    property p_half_no_pause;
        @(posedge CLK_I) disable iff (RST_I)
        LINK_I.half_duplex |=> !FC_O.port1_rx_pause_active && !FC_O.port1_tx_pause_active && dup_q;
    endproperty
    a_half_no_pause: assert property (p_half_no_pause) else $error("pause active in half duplex");

    property p_resv_zero;
        @(posedge CLK_I) disable iff (RST_I)
        CSR_REQ_I.rd |=> CSR_RVALID_O && (CSR_RDATA_O[DATA_W-1:RESV_LO] == '0);
    endproperty
    a_resv_zero: assert property (p_resv_zero) else $error("reserved bits read non-zero");

    property p_strap_load;
        @(posedge CLK_I) disable iff (RST_I)
        s_strap_load |=> (bp_q == $past(STRAP_I.backpressure_default_strap))
            && (rx_en_q == $past(STRAP_I.pause_enable_default_strap))
            && (msel_q == $past(STRAP_I.manual_select_default_strap)) ##1 loaded_q;
    endproperty
    a_strap_load: assert property (p_strap_load) else $error("straps not loaded into the register");

    property p_read_image;
        @(posedge CLK_I) disable iff (RST_I)
        (CSR_REQ_I.rd && hit) |=> (CSR_RDATA_O[BIT_MAN_SEL] == $past(msel_q))
            && (CSR_RDATA_O[BIT_RX_ACTIVE] == $past(crx_q));
    endproperty
    a_read_image: assert property (p_read_image) else $error("read data does not match the register");

    // Each remaining writable control bit takes exactly what software wrote to it.
    property p_rx_en_write;
        @(posedge CLK_I) disable iff (RST_I)
        s_sw_write |=> rx_en_q == $past(CSR_REQ_I.wdata[BIT_RX_EN]);
    endproperty
    a_rx_en_write: assert property (p_rx_en_write) else $error("receive enable not written");

    property p_tx_en_write;
        @(posedge CLK_I) disable iff (RST_I)
        s_sw_write |=> tx_en_q == $past(CSR_REQ_I.wdata[BIT_TX_EN]);
    endproperty
    a_tx_en_write: assert property (p_tx_en_write) else $error("transmit enable not written");

    property p_msel_write;
        @(posedge CLK_I) disable iff (RST_I)
        s_sw_write |=> msel_q == $past(CSR_REQ_I.wdata[BIT_MAN_SEL]);
    endproperty
    a_msel_write: assert property (p_msel_write) else $error("manual select not written");

    // The single pause strap also seeds the transmit enable.
    property p_strap_tx;
        @(posedge CLK_I) disable iff (RST_I)
        s_strap_load |=> tx_en_q == $past(STRAP_I.pause_enable_default_strap);
    endproperty
    a_strap_tx: assert property (p_strap_tx) else $error("transmit enable not loaded from strap");

    // The remaining register bits read back as stored.
    property p_read_ctrl;
        @(posedge CLK_I) disable iff (RST_I)
        (CSR_REQ_I.rd && hit) |=> (CSR_RDATA_O[BIT_BP_EN] == $past(bp_q))
            && (CSR_RDATA_O[BIT_DUPLEX] == $past(dup_q))
            && (CSR_RDATA_O[BIT_TX_ACTIVE] == $past(ctx_q))
            && (CSR_RDATA_O[BIT_RX_EN] == $past(rx_en_q))
            && (CSR_RDATA_O[BIT_TX_EN] == $past(tx_en_q));
    endproperty
    a_read_ctrl: assert property (p_read_ctrl) else $error("read data does not match the control bits");

    // Read data is zero unless it answers a read of this register.
    property p_read_idle;
        @(posedge CLK_I) disable iff (RST_I)
        (!CSR_REQ_I.rd || !hit) |=> (CSR_RDATA_O == READ_ZERO);
    endproperty
    a_read_idle: assert property (p_read_idle) else $error("read data not zero outside a hit");

    // The read answer flag only follows a read request.
    property p_rvalid_idle;
        @(posedge CLK_I) disable iff (RST_I)
        !CSR_REQ_I.rd |=> !CSR_RVALID_O;
    endproperty
    a_rvalid_idle: assert property (p_rvalid_idle) else $error("read answer without a read");

endmodule : port_fc_select

`default_nettype wire

// file: bench/port_fc_select_tb.sv
/*
 * Self-checking testbench for the port one flow-control select register.
 * Assumes the package and design module are compiled first; drives all inputs on the falling clock edge.
 */
`timescale 1ns/1ps
`default_nettype none

module port_fc_select_tb;
    import port_fc_pkg::*;

    logic clk;
    logic rst;
    logic reload;
    csr_req_s req;
    strap_s strap;
    link_s link;
    logic [DATA_W-1:0] rdata;
    logic rvalid;
    fc_out_s fc;
    logic bp;
    logic rxe;
    logic txe;
    logic ms;
    int bad_count;
    int checks_done;

    ////////////////////////////////////////////////////////////////////////////////////////////////////
    // Device under test.
    port_fc_select uut
    (
        .CLK_I(clk),
        .RST_I(rst),
        .CSR_REQ_I(req),
        .CSR_RDATA_O(rdata),
        .CSR_RVALID_O(rvalid),
        .STRAP_I(strap),
        .STRAP_RELOAD_I(reload),
        .LINK_I(link),
        .FC_O(fc)
    );

    // The 10 MHz system clock.
    initial
    begin
        clk = 1'h0;
        forever #50 clk = ~clk;
    end

    ////////////////////////////////////////////////////////////////////////////////////////////////////
    // Expected register image from the control model and the current link state.
    function automatic logic [DATA_W-1:0] img();
        logic man;
        logic rx;
        logic tx;
        man = ms | ~link.autoneg_enable;
        rx = ~link.half_duplex & (man ? rxe : link.an_rx_pause);
        tx = ~link.half_duplex & (man ? txe : link.an_tx_pause);
        return {25'h0, bp, link.half_duplex, rx, tx, rxe, txe, ms};
    endfunction : img

    // Compares one value and reports a mismatch at once.
    task automatic chk(input string name, input logic [DATA_W-1:0] e, input logic [DATA_W-1:0] g);
        checks_done++;
        if (g !== e)
        begin
            bad_count++;
            $display("CHECK FAILED %s expected %h seen %h", name, e, g);
        end
    endtask : chk

    // One write cycle; the control model follows writes to the mapped offset.
    task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
        @(negedge clk);
        req = '{wr: 1'h1, rd: 1'h0, addr: a, wdata: d};
        if (a == FC_REG_OFFSET)
        begin
            {bp, rxe, txe, ms} = {d[BIT_BP_EN], d[BIT_RX_EN], d[BIT_TX_EN], d[BIT_MAN_SEL]};
        end
        @(negedge clk);
        req = '0;
    endtask : wr

    // One read cycle after the status has settled; also checks the outputs to the MAC.
    task automatic rd(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] e);
        logic [DATA_W-1:0] x;
        repeat (3) @(negedge clk);
        req = '{wr: 1'h0, rd: 1'h1, addr: a, wdata: 32'h0};
        @(negedge clk);
        req = '0;
        x = img();
        chk("rvalid", 32'h1, {31'h0, rvalid});
        chk("rdata", e, rdata);
        chk("fc_out", {28'h0, x[BIT_BP_EN], x[BIT_RX_ACTIVE], x[BIT_TX_ACTIVE], x[BIT_DUPLEX]}, {28'h0, fc});
        // The answer stands for one cycle only, then falls back to zero.
        @(negedge clk);
        chk("rvalid_end", 32'h0, {31'h0, rvalid});
        chk("rdata_end", 32'h0, rdata);
    endtask : rd

    // Prints the verdict and ends the run.
    task automatic test_done();
        if (bad_count == 0 && checks_done > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : test_done

    ////////////////////////////////////////////////////////////////////////////////////////////////////
    // Main sequence: reset defaults, writes, mode table, reload and a second reset.
    initial
    begin
        bad_count = 0;
        checks_done = 0;
        req = '0;
        reload = 1'h0;
        strap = '{1'h1, 1'h1, 1'h0};
        link = '{autoneg_enable: 1'h1, half_duplex: 1'h0, an_rx_pause: 1'h0, an_tx_pause: 1'h1};
        {bp, rxe, txe, ms} = 4'h6 | 4'h8;
        rst = 1'h1;
        repeat (12) @(negedge clk);
        rst = 1'h0;
        rd(FC_REG_OFFSET, img());
        wr(FC_REG_OFFSET, 32'hFFFFFFFF);
        rd(FC_REG_OFFSET, img());
        wr(12'h1A4, 32'h0);
        rd(FC_REG_OFFSET, img());
        rd(12'h1A4, 32'h0);
        link.half_duplex = 1'h1;
        rd(FC_REG_OFFSET, img());
        link.half_duplex = 1'h0;
        // Every selection mode, first with the negotiated result opposite to the manual bits, then with the receive result equal to them.
        for (int i = 0; i < 8; i++)
        begin
            link.autoneg_enable = i[1];
            link.an_rx_pause = ~i[2];
            link.an_tx_pause = i[2];
            wr(FC_REG_OFFSET, {25'h0, 4'h0, i[2], ~i[2], i[0]});
            rd(FC_REG_OFFSET, img());
            link.an_rx_pause = i[2];
            rd(FC_REG_OFFSET, img());
        end
        wr(FC_REG_OFFSET, 32'h40);
        rd(FC_REG_OFFSET, img());
        wr(FC_REG_OFFSET, 32'h0);
        rd(FC_REG_OFFSET, img());
        // Loader reload wins over a write in the same cycle.
        strap = '{1'h0, 1'h1, 1'h1};
        @(negedge clk);
        req = '{wr: 1'h1, rd: 1'h0, addr: FC_REG_OFFSET, wdata: 32'h40};
        reload = 1'h1;
        @(negedge clk);
        req = '0;
        reload = 1'h0;
        {bp, rxe, txe, ms} = 4'h7;
        rd(FC_REG_OFFSET, img());
        // Second reset with other strap levels.
        strap = '{1'h1, 1'h0, 1'h1};
        rst = 1'h1;
        repeat (3) @(negedge clk);
        rst = 1'h0;
        {bp, rxe, txe, ms} = 4'h9;
        rd(FC_REG_OFFSET, img());
        test_done();
    end

endmodule : port_fc_select_tb

`default_nettype wire
